//--- rtl/phy_basic_params.svh
// Constants for the basic control and status register bank
`ifndef PHY_BASIC_PARAMS_SVH
`define PHY_BASIC_PARAMS_SVH

// ==========================================================
// Register indices
`define IDX_CONTROL 5'h00
`define IDX_STATUS 5'h01

// ==========================================================
// Control field positions
`define CTL_SOFT_RESET 15
`define CTL_LOOPBACK 14
`define CTL_SPEED 13
`define CTL_AUTONEG 12
`define CTL_POWER_DOWN 11
`define CTL_AN_RESTART 9
`define CTL_DUPLEX 8
`define CTL_COL_TEST 7

// ==========================================================
// Status layout
`define STATUS_FIXED 16'h7809
`define STS_LINK 2
`define STS_AN_DONE 5

// ==========================================================
// Serial management framing
`define MDIO_PREAMBLE_BITS 6'h20
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1
`define MDIO_ADDR_LAST 5'h04
`define MDIO_TA_LAST 5'h01
`define MDIO_DATA_LAST 5'h0F

`endif

//--- rtl/phy_basic_pkg.sv
// Types shared by the basic control and status register bank
package phy_basic_pkg;

  // ==========================================================
  // Stored control fields
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic autoneg;
    logic power_down;
    logic full_duplex;
    logic col_test;
  } ctrl_t;

  // ==========================================================
  // Configuration straps caught after reset
  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
    logic fiber;
  } straps_t;

  // ==========================================================
  // Serial management frame phases
  typedef enum logic [2:0] {
    M_PRE,
    M_ST,
    M_OP,
    M_PHY,
    M_REG,
    M_TA,
    M_DATA
  } mdio_state_t;

endpackage : phy_basic_pkg

//--- rtl/phy_basic_control_status_regs.sv
// Basic control and status registers with serial and host access
`timescale 1ns/1ps
`include "phy_basic_params.svh"

module phy_basic_control_status_regs
  import phy_basic_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Straps and live configuration
  input wire logic autoneg_strap_i,
  input wire logic speed_strap_i,
  input wire logic duplex_strap_i,
  input wire logic [4:0] phy_addr_i,
  input wire logic fiber_mode_i,
  // Serial management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Host indirect access
  input wire logic host_req_i,
  input wire logic host_we_i,
  input wire logic [4:0] host_index_i,
  input wire logic [15:0] host_wdata_i,
  output logic host_ack_o,
  output logic [15:0] host_rdata_o,
  // PHY core status
  input wire logic link_up_i,
  input wire logic an_done_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire logic tx_en_i,
  // PHY core controls
  output logic soft_reset_o,
  output logic an_restart_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic autoneg_en_o,
  output logic power_down_o,
  output logic line_tx_en_o,
  output logic loop_rx_en_o,
  output logic collision_o
);

  // ==========================================================
  // Decoding helpers
  function automatic ctrl_t ctrl_default(input straps_t s);
    ctrl_t c;
    c = '0;
    c.speed_100 = s.fiber ? 1'b1 : (s.autoneg | s.speed);
    c.autoneg = s.fiber ? 1'b0 : s.autoneg;
    c.full_duplex = s.fiber ? s.duplex : (~s.autoneg & s.duplex);
    return c;
  endfunction : ctrl_default

  function automatic logic [15:0] ctrl_word(input ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`CTL_LOOPBACK] = c.loopback;
    w[`CTL_SPEED] = c.speed_100;
    w[`CTL_AUTONEG] = c.autoneg;
    w[`CTL_POWER_DOWN] = c.power_down;
    w[`CTL_DUPLEX] = c.full_duplex;
    w[`CTL_COL_TEST] = c.col_test;
    return w;
  endfunction : ctrl_word

  // ==========================================================
  // Declarations
  straps_t straps_q;
  logic straps_taken_q;
  ctrl_t ctrl_q;
  logic link_ok_q;
  logic [2:0] mdc_sync_q;
  logic [2:0] mdio_sync_q;
  logic mdc_lvl_q;
  logic mdio_lvl_q;
  mdio_state_t mstate_q;
  logic [5:0] pre_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [1:0] op_q;
  logic [4:0] phy_q;
  logic [4:0] reg_q;
  logic [15:0] shift_q;
  logic mdc_rise;
  logic mdio_bit;
  logic addr_hit;
  logic mdio_rd_fire;
  logic mdio_wr_fire;
  logic host_take;
  logic wr_fire;
  logic rd_fire;
  logic [4:0] acc_index;
  logic [15:0] acc_wdata;
  logic [15:0] rd_word;
  logic status_read;

  // ==========================================================
  // Strap capture one cycle after reset release
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      straps_q <= '0;
      straps_taken_q <= 1'b0;
    end
    else if (!straps_taken_q)
    begin
      straps_q <= '{autoneg: autoneg_strap_i, speed: speed_strap_i, duplex: duplex_strap_i, fiber: fiber_mode_i};
      straps_taken_q <= 1'b1;
    end
  end

  // ==========================================================
  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mdc_sync_q <= 3'h0;
      mdio_sync_q <= 3'h7;
      mdc_lvl_q <= 1'b0;
      mdio_lvl_q <= 1'b1;
    end
    else
    begin
      mdc_sync_q <= {mdc_sync_q[1:0], mdc_i};
      mdio_sync_q <= {mdio_sync_q[1:0], mdio_i};
      if (mdc_sync_q[1] == mdc_sync_q[2])
        mdc_lvl_q <= mdc_sync_q[2];
      if (mdio_sync_q[1] == mdio_sync_q[2])
        mdio_lvl_q <= mdio_sync_q[2];
    end
  end

  // Both filtered levels lag the same, so data is sampled at its own edge
  assign mdc_rise = ~mdc_lvl_q & (mdc_sync_q[1] == mdc_sync_q[2]) & mdc_sync_q[2];
  assign mdio_bit = (mdio_sync_q[1] == mdio_sync_q[2]) ? mdio_sync_q[2] : mdio_lvl_q;
  assign addr_hit = (phy_q == phy_addr_i);

  // ==========================================================
  // Frame decode: read captures at address end, write commits on last bit
  assign mdio_rd_fire = mdc_rise & (mstate_q == M_REG) & (bit_cnt_q == `MDIO_ADDR_LAST)
                        & (op_q == `MDIO_OP_READ) & addr_hit;
  assign mdio_wr_fire = mdc_rise & (mstate_q == M_DATA) & (bit_cnt_q == `MDIO_DATA_LAST)
                        & (op_q == `MDIO_OP_WRITE) & addr_hit;

  // Host waits a cycle when the serial path is using the port
  assign host_take = host_req_i & ~host_ack_o & ~mdio_rd_fire & ~mdio_wr_fire;
  assign wr_fire = mdio_wr_fire | (host_take & host_we_i);
  assign rd_fire = mdio_rd_fire | (host_take & ~host_we_i);
  assign acc_index = mdio_rd_fire ? {reg_q[3:0], mdio_bit} : (mdio_wr_fire ? reg_q : host_index_i);
  assign acc_wdata = mdio_wr_fire ? {shift_q[14:0], mdio_bit} : host_wdata_i;
  assign status_read = rd_fire & (acc_index == `IDX_STATUS);

  // Read multiplexer; indices outside this bank read zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (acc_index == `IDX_CONTROL)
      rd_word = ctrl_word(ctrl_q);
    else if (acc_index == `IDX_STATUS)
    begin
      rd_word = `STATUS_FIXED;
      rd_word[`STS_LINK] = link_ok_q & link_up_i;
      rd_word[`STS_AN_DONE] = an_done_i;
    end
  end

  // ==========================================================
  // Serial management state machine
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mstate_q <= M_PRE;
      pre_cnt_q <= 6'h00;
      bit_cnt_q <= 5'h00;
      op_q <= 2'h0;
      phy_q <= 5'h00;
      reg_q <= 5'h00;
      shift_q <= 16'h0000;
      mdio_o <= 1'b1;
      mdio_oe_o <= 1'b0;
    end
    else if (mdc_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      unique case (mstate_q)
        M_PRE:
        begin
          bit_cnt_q <= 5'h00;
          if (mdio_bit)
            pre_cnt_q <= (pre_cnt_q == `MDIO_PREAMBLE_BITS) ? pre_cnt_q : pre_cnt_q + 6'h01;
          else
          begin
            pre_cnt_q <= 6'h00;
            if (pre_cnt_q == `MDIO_PREAMBLE_BITS)
              mstate_q <= M_ST;
          end
        end
        M_ST:
        begin
          bit_cnt_q <= 5'h00;
          mstate_q <= mdio_bit ? M_OP : M_PRE;
        end
        M_OP:
        begin
          op_q <= {op_q[0], mdio_bit};
          if (bit_cnt_q == 5'h01)
          begin
            bit_cnt_q <= 5'h00;
            mstate_q <= M_PHY;
          end
        end
        M_PHY:
        begin
          phy_q <= {phy_q[3:0], mdio_bit};
          if (bit_cnt_q == `MDIO_ADDR_LAST)
          begin
            bit_cnt_q <= 5'h00;
            mstate_q <= M_REG;
          end
        end
        M_REG:
        begin
          reg_q <= {reg_q[3:0], mdio_bit};
          if (bit_cnt_q == `MDIO_ADDR_LAST)
          begin
            bit_cnt_q <= 5'h00;
            mstate_q <= M_TA;
            shift_q <= rd_word;
          end
        end
        M_TA:
        begin
          // Second turnaround bit is driven low on a read for us
          if (op_q == `MDIO_OP_READ && addr_hit)
          begin
            mdio_oe_o <= 1'b1;
            mdio_o <= (bit_cnt_q == 5'h00) ? 1'b0 : shift_q[15];
            if (bit_cnt_q != 5'h00)
              shift_q <= {shift_q[14:0], 1'b0};
          end
          if (bit_cnt_q == `MDIO_TA_LAST)
          begin
            bit_cnt_q <= 5'h00;
            mstate_q <= M_DATA;
          end
        end
        M_DATA:
        begin
          if (op_q == `MDIO_OP_READ && addr_hit)
          begin
            mdio_o <= shift_q[15];
            shift_q <= {shift_q[14:0], 1'b0};
            mdio_oe_o <= (bit_cnt_q != `MDIO_DATA_LAST);
          end
          else
            shift_q <= {shift_q[14:0], mdio_bit};
          if (bit_cnt_q == `MDIO_DATA_LAST)
          begin
            mstate_q <= M_PRE;
            pre_cnt_q <= 6'h00;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Host answer, one cycle after the request is taken
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      host_ack_o <= 1'b0;
      host_rdata_o <= 16'h0000;
    end
    else
    begin
      host_ack_o <= host_take;
      if (host_take && !host_we_i)
        host_rdata_o <= rd_word;
    end
  end

  // ==========================================================
  // Control register; status index and reserved bits drop writes
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_q <= '0;
    else
    begin
      if (!straps_taken_q)
        ctrl_q <= ctrl_default('{autoneg: autoneg_strap_i, speed: speed_strap_i,
                                 duplex: duplex_strap_i, fiber: fiber_mode_i});
      else if (wr_fire && acc_index == `IDX_CONTROL)
      begin
        if (acc_wdata[`CTL_SOFT_RESET])
        begin
          // Reload defaults, but live fiber mode still holds autoneg off
          ctrl_q <= ctrl_default(straps_q);
          if (fiber_mode_i)
            ctrl_q.autoneg <= 1'b0;
        end
        else
        begin
          ctrl_q.loopback <= acc_wdata[`CTL_LOOPBACK];
          ctrl_q.speed_100 <= acc_wdata[`CTL_SPEED];
          ctrl_q.autoneg <= acc_wdata[`CTL_AUTONEG] & ~fiber_mode_i;
          ctrl_q.power_down <= acc_wdata[`CTL_POWER_DOWN];
          ctrl_q.full_duplex <= acc_wdata[`CTL_DUPLEX];
          ctrl_q.col_test <= acc_wdata[`CTL_COL_TEST];
        end
      end
      else if (fiber_mode_i)
        ctrl_q.autoneg <= 1'b0;
    end
  end

  // ==========================================================
  // Latched-low link; a drop in the read cycle still wins
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      link_ok_q <= 1'b0;
    else if (!link_up_i)
      link_ok_q <= 1'b0;
    else if (status_read)
      link_ok_q <= 1'b1;
  end

  // ==========================================================
  // Registered controls toward the PHY core
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      soft_reset_o <= 1'b0;
      an_restart_o <= 1'b0;
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
      autoneg_en_o <= 1'b0;
      power_down_o <= 1'b0;
      line_tx_en_o <= 1'b0;
      loop_rx_en_o <= 1'b0;
      collision_o <= 1'b0;
    end
    else
    begin
      // Self-clearing bits exist only as one-cycle pulses
      soft_reset_o <= wr_fire & (acc_index == `IDX_CONTROL) & acc_wdata[`CTL_SOFT_RESET];
      an_restart_o <= wr_fire & (acc_index == `IDX_CONTROL) & acc_wdata[`CTL_AN_RESTART]
                      & ~acc_wdata[`CTL_SOFT_RESET];
      speed_100_o <= ctrl_q.autoneg ? an_speed_100_i : ctrl_q.speed_100;
      full_duplex_o <= ctrl_q.autoneg ? an_full_duplex_i : ctrl_q.full_duplex;
      autoneg_en_o <= ctrl_q.autoneg;
      power_down_o <= ctrl_q.power_down;
      line_tx_en_o <= tx_en_i & ~ctrl_q.loopback;
      loop_rx_en_o <= tx_en_i & ctrl_q.loopback;
      collision_o <= tx_en_i & ctrl_q.col_test;
    end
  end

endmodule : phy_basic_control_status_regs

//--- tb/phy_basic_control_status_regs_sva.sv
// Port assertions for the basic control and status register bank
`timescale 1ns/1ps
module phy_regs_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Inputs that cause outputs
  input wire logic fiber_mode_i,
  input wire logic tx_en_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire logic host_req_i,
  // Watched outputs
  input wire logic host_ack_o,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic soft_reset_o,
  input wire logic an_restart_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o,
  input wire logic autoneg_en_o,
  input wire logic line_tx_en_o,
  input wire logic loop_rx_en_o,
  input wire logic collision_o
);
  // ========
  // One clock domain, so clocking is shared
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  tx_path_a: assert property (
    (line_tx_en_o || loop_rx_en_o) |-> $past(tx_en_i) && !(line_tx_en_o && loop_rx_en_o)) else $error("tx path");
  col_test_a: assert property (
    collision_o |-> $past(tx_en_i)) else $error("collision without tx");
  srst_pulse_a: assert property (
    soft_reset_o |=> !soft_reset_o [*2]) else $error("soft reset stuck");
  restart_pulse_a: assert property (
    $rose(an_restart_o) |=> $fell(an_restart_o)) else $error("restart stuck");
  fiber_an_a: assert property (
    $past(fiber_mode_i) && $past(fiber_mode_i, 2) |-> !autoneg_en_o) else $error("autoneg in fiber");
  an_speed_a: assert property (
    autoneg_en_o |-> speed_100_o == $past(an_speed_100_i)) else $error("speed not negotiated");
  an_duplex_a: assert property (
    autoneg_en_o |-> full_duplex_o == $past(an_full_duplex_i)) else $error("duplex not negotiated");
  host_ack_a: assert property (
    host_ack_o |-> $past(host_req_i) ##1 !host_ack_o) else $error("ack wrong");
  turnaround_a: assert property (
    $rose(mdio_oe_o) |-> !mdio_o) else $error("turnaround not zero");
endmodule : phy_regs_sva

bind phy_basic_control_status_regs phy_regs_sva chk_u (.*);

//--- tb/phy_mgmt_master.sv
// Serial management master model driving the pins
`timescale 1ns/1ps
module phy_mgmt_master (
  // Pins
  output logic mdc_o,
  output logic line_o,
  // Device drive
  input wire logic dev_d_i,
  input wire logic dev_oe_i
);
  logic drive_en = 1'h0;
  logic drive_val = 1'h1;
  // Pull-up wins when nobody drives, so no stale bit lingers
  assign line_o = dev_oe_i ? dev_d_i : (drive_en ? drive_val : 1'h1);
  initial mdc_o = 1'h0;
  // Whole frame; clock stands low between frames
  task automatic frame(input logic wr, input logic [4:0] adr, input logic [4:0] idx, inout logic [15:0] data);
    logic [63:0] sh;
    sh = {32'hFFFFFFFF, 2'h1, wr ? 2'h1 : 2'h2, adr, idx, 2'h2, data};
    for (int i = 63; i >= 0; i--)
    begin
      drive_en = wr || (i > 17);
      drive_val = sh[i];
      #24 mdc_o = 1'h1;
      if (i < 16) data[i] = line_o;
      #24 mdc_o = 1'h0;
    end
    drive_en = 1'h0;
  endtask : frame
endmodule : phy_mgmt_master

//--- tb/test_phy_basic_control_status_regs.sv
// Self-checking bench for the basic control and status register bank
`timescale 1ns/1ps
`include "phy_basic_params.svh"
module test_phy_basic_control_status_regs import phy_basic_pkg::*;;
  localparam logic [4:0] ADR = 5'h05;
  logic mclk = 1'h0, rst_b = 1'h0, req = 1'h0, we = 1'h0, link = 1'h1, tx = 1'h0, an_spd = 1'h0, an_fd = 1'h0;
  logic [4:0] idx = 5'h00;
  logic [15:0] wdat = 16'h0000, rdat, hrd, d;
  straps_t st = 4'h0;
  logic mdc, line, md_o, md_oe, ack, srst, anr, spd, fd, ane, pd, ltx, lrx, col;
  int num_errors = 0, cmp_count = 0;
  wire logic [15:0] outs = {9'h000, spd, fd, ane, pd, ltx, lrx, col};
  always #2 mclk = ~mclk;
  // ========
  // Device and far-side master
  phy_basic_control_status_regs dut_u (
    .mclk_i(mclk), .rst_b_i(rst_b), .autoneg_strap_i(st.autoneg), .speed_strap_i(st.speed),
    .duplex_strap_i(st.duplex), .phy_addr_i(ADR), .fiber_mode_i(st.fiber), .mdc_i(mdc), .mdio_i(line),
    .mdio_o(md_o), .mdio_oe_o(md_oe), .host_req_i(req), .host_we_i(we), .host_index_i(idx),
    .host_wdata_i(wdat), .host_ack_o(ack), .host_rdata_o(rdat), .link_up_i(link), .an_done_i(1'h0),
    .an_speed_100_i(an_spd), .an_full_duplex_i(an_fd), .tx_en_i(tx), .soft_reset_o(srst),
    .an_restart_o(anr), .speed_100_o(spd), .full_duplex_o(fd), .autoneg_en_o(ane), .power_down_o(pd),
    .line_tx_en_o(ltx), .loop_rx_en_o(lrx), .collision_o(col));
  phy_mgmt_master mst_u (.mdc_o(mdc), .line_o(line), .dev_d_i(md_o), .dev_oe_i(md_oe));
  // ========
  // Shared helpers
  task automatic give_verdict;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Bounded wait step; a spent bound ends the run
  task automatic guard(input int n);
    if (n > 40)
    begin
      num_errors++;
      $display("Error wait expected 1 seen 0");
      give_verdict();
    end
    @(negedge mclk);
  endtask : guard
  task automatic do_reset(input straps_t s);
    st = s;
    rst_b = 1'h0;
    repeat (6) @(negedge mclk);
    rst_b = 1'h1;
    repeat (3) @(negedge mclk);
  endtask : do_reset
  // Request held until ack is seen, then dropped
  task automatic host(input logic w, input logic [4:0] i, input logic [15:0] dat);
    req = 1'h1;
    we = w;
    idx = i;
    wdat = dat;
    for (int n = 0; ack !== 1'h1; n++) guard(n);
    hrd = rdat;
    req = 1'h0;
    @(negedge mclk);
  endtask : host
  task automatic pulse_wait(input logic rst_sel);
    for (int n = 0; (rst_sel ? srst : anr) !== 1'h1; n++) guard(n);
  endtask : pulse_wait
  // ========
  // Scenarios
  task automatic t_defaults;
    straps_t s;
    for (int k = 0; k < 16; k++)
    begin
      s = straps_t'(k[3:0]);
      do_reset(s);
      host(1'h0, `IDX_CONTROL, 16'h0000);
      chk("defaults", {2'h0, s.fiber | s.autoneg | s.speed, s.autoneg & !s.fiber, 3'h0,
        s.fiber ? s.duplex : !s.autoneg & s.duplex, 8'h00}, hrd);
    end
    do_reset(4'h0);
    $display("Test defaults done");
  endtask : t_defaults
  task automatic t_status;
    host(1'h0, `IDX_STATUS, 16'h0000);
    host(1'h1, `IDX_STATUS, 16'h0000);
    host(1'h0, `IDX_STATUS, 16'h0000);
    chk("status", 16'h780D, hrd);
    link = 1'h0;
    @(negedge mclk);
    link = 1'h1;
    host(1'h0, `IDX_STATUS, 16'h0000);
    chk("status drop", 16'h7809, hrd);
    host(1'h0, `IDX_STATUS, 16'h0000);
    chk("status back", 16'h780D, hrd);
    host(1'h0, 5'h02, 16'h0000);
    chk("unmapped", 16'h0000, hrd);
    $display("Test status done");
  endtask : t_status
  task automatic t_serial;
    d = 16'h2100;
    mst_u.frame(1'h1, ADR, `IDX_CONTROL, d);
    d = 16'h4000;
    mst_u.frame(1'h1, ADR + 5'h01, `IDX_CONTROL, d);
    repeat (2) @(negedge mclk);
    host(1'h0, `IDX_CONTROL, 16'h0000);
    chk("serial write", 16'h2100, hrd);
    d = 16'h0000;
    mst_u.frame(1'h0, ADR, `IDX_STATUS, d);
    chk("serial read", 16'h780D, d);
    @(negedge mclk);
    $display("Test serial done");
  endtask : t_serial
  task automatic t_forced;
    logic [15:0] w [2] = '{16'h4DFF, 16'h227F};
    tx = 1'h1;
    foreach (w[k])
    begin
      host(1'h1, `IDX_CONTROL, w[k]);
      host(1'h0, `IDX_CONTROL, 16'h0000);
      chk("control", w[k] & 16'h7980, hrd);
      chk("outputs", {9'h000, w[k][13], w[k][8], 1'h0, w[k][11], !w[k][14], w[k][14], w[k][7]}, outs);
    end
    tx = 1'h0;
    $display("Test forced done");
  endtask : t_forced
  task automatic t_autoneg;
    an_spd = 1'h1;
    host(1'h1, `IDX_CONTROL, 16'h1100);
    chk("negotiated", 16'h0050, outs);
    fork
      host(1'h1, `IDX_CONTROL, 16'h1300);
      pulse_wait(1'h0);
    join
    st.fiber = 1'h1;
    repeat (3) @(negedge mclk);
    chk("fiber outputs", 16'h0020, outs);
    host(1'h0, `IDX_CONTROL, 16'h0000);
    chk("fiber control", 16'h0100, hrd);
    st.fiber = 1'h0;
    $display("Test autoneg done");
  endtask : t_autoneg
  task automatic t_soft;
    host(1'h1, `IDX_CONTROL, 16'h4980);
    fork
      host(1'h1, `IDX_CONTROL, 16'hC000);
      pulse_wait(1'h1);
    join
    repeat (2) @(negedge mclk);
    host(1'h0, `IDX_CONTROL, 16'h0000);
    chk("after soft reset", 16'h0000, hrd);
    chk("soft outputs", 16'h0000, outs);
    $display("Test soft reset done");
  endtask : t_soft
  initial
  begin
    t_defaults();
    t_status();
    t_serial();
    t_forced();
    t_autoneg();
    t_soft();
    give_verdict();
  end
endmodule : test_phy_basic_control_status_regs
